// ### bmd_pkg.sv
// Shared constants and types for the banked data memory decoder.
package bmd_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned GP_AW = 7;
  localparam int unsigned GP_DEPTH = 128;

  typedef logic [DATA_W-1:0] bmd_byte_t;

  // Locations of the two indirect ports and of the registers held inside this block.
  localparam bmd_byte_t ADDR_IND0 = 8'h00;
  localparam bmd_byte_t ADDR_PTR0 = 8'h01;
  localparam bmd_byte_t ADDR_IND1 = 8'h02;
  localparam bmd_byte_t ADDR_PTR1 = 8'h03;
  localparam bmd_byte_t ADDR_BANK = 8'h04;

  // Decoding landmarks.
  localparam bmd_byte_t ADDR_EEC = 8'h40;
  localparam bmd_byte_t ADDR_GP_BASE = 8'h80;
  localparam bmd_byte_t GP_TOP_SMALL = 8'hDF;
  localparam bmd_byte_t GP_TOP_LARGE = 8'hFF;

  // Values.
  localparam bmd_byte_t PTR_RST = 8'h00;
  localparam logic BANK_RST = 1'b0;
  localparam bmd_byte_t ZERO_BYTE = 8'h00;
  localparam bmd_byte_t FULL_MASK = 8'hFF;
  localparam bmd_byte_t BIT_ONE = 8'h01;
  localparam int unsigned BANK_BIT = 0;

  // Special function locations below the general area that hold nothing.
  localparam logic [127:0] SFR_UNUSED_MAP = 128'hFF00_0102_0402_0101_0002_0100_0500_1000;
  // Special function locations that are read only.
  localparam logic [127:0] SFR_PROT_MAP = 128'h0000_0000_0000_0000_0000_0000_0000_0100;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_PTR0,
    TGT_PTR1,
    TGT_BANK,
    TGT_SFR,
    TGT_MEM
  } bmd_target_t;

  typedef enum logic [1:0] {
    SRC_ZERO,
    SRC_HOLD,
    SRC_SFR,
    SRC_MEM
  } bmd_src_t;

endpackage

// ### bmd_mem_if.sv
// Connection between the decoder and its general purpose byte store.
`timescale 1ns/1ps
interface bmd_mem_if;
  import bmd_pkg::*;

  logic [GP_AW-1:0] addr;
  logic rd_en;
  logic wr_en;
  bmd_byte_t wdata;
  bmd_byte_t wmask;
  bmd_byte_t rdata;

  modport ctrl (
    output addr,
    output rd_en,
    output wr_en,
    output wdata,
    output wmask,
    input rdata
  );

  modport store (
    input addr,
    input rd_en,
    input wr_en,
    input wdata,
    input wmask,
    output rdata
  );
endinterface

// ### bmd_mem.sv
// General purpose byte store with per-bit write enables and registered read data.
`timescale 1ns/1ps
module bmd_mem
  import bmd_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Access port.
  bmd_mem_if.store mem
);

  bmd_byte_t ram [GP_DEPTH];
  bmd_byte_t word_d;
  bmd_byte_t rdata_d;
  bmd_byte_t rdata_q;

  // Only the bits selected by the mask change, so bit operations keep the rest.
  always_comb
  begin
    word_d = (ram[mem.addr] & ~mem.wmask) | (mem.wdata & mem.wmask);
    rdata_d = mem.rd_en ? ram[mem.addr] : rdata_q;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (mem.wr_en)
    begin
      ram[mem.addr] <= word_d;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_q <= ZERO_BYTE;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign mem.rdata = rdata_q;

endmodule

// ### bmd_top.sv
// Banked data memory decoder: pointers, bank selection, decoding and general RAM.
`timescale 1ns/1ps
module bmd_top
  import bmd_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic wdt_pd_reset_i,
  // Core data access.
  input wire logic [7:0] acc_addr_i,
  input wire logic acc_rd_i,
  input wire logic acc_wr_i,
  input wire logic acc_bset_i,
  input wire logic acc_bclr_i,
  input wire logic [2:0] acc_bit_i,
  input wire bmd_pkg::bmd_byte_t acc_wdata_i,
  output logic [7:0] acc_rdata_o,
  // Peripheral special function registers.
  output logic [6:0] sfr_addr_o,
  output logic sfr_rd_o,
  output logic sfr_wr_o,
  output bmd_pkg::bmd_byte_t sfr_wdata_o,
  output bmd_pkg::bmd_byte_t sfr_wmask_o,
  input wire bmd_pkg::bmd_byte_t sfr_rdata_i,
  // Bank state.
  output logic bank_sel_o
);

  import bmd_pkg::*;

  localparam bmd_byte_t GP_TOP = LARGE_VARIANT ? GP_TOP_LARGE : GP_TOP_SMALL;

  function automatic logic in_gp(input bmd_byte_t a);
    in_gp = (a >= ADDR_GP_BASE) && (a <= GP_TOP);
  endfunction

  function automatic bmd_byte_t make_mask(input logic wr, input logic bit_op,
                                          input logic [2:0] b);
    make_mask = (!wr && bit_op) ? (BIT_ONE << b) : FULL_MASK;
  endfunction

  function automatic bmd_byte_t make_data(input logic wr, input logic bset,
                                          input bmd_byte_t d);
    if (wr)
    begin
      make_data = d;
    end
    else
    begin
      make_data = bset ? FULL_MASK : ZERO_BYTE;
    end
  endfunction

  function automatic bmd_byte_t apply_mask(input bmd_byte_t old, input bmd_byte_t d,
                                           input bmd_byte_t m);
    apply_mask = (old & ~m) | (d & m);
  endfunction

  bmd_mem_if mem_bus ();

  logic is_wr;
  logic is_acc;
  logic ind0;
  logic ind1;
  logic eff_bank1;
  bmd_byte_t eff_addr;
  bmd_byte_t wmask;
  bmd_byte_t wdata;
  bmd_target_t tgt_d;

  bmd_byte_t ptr0_d, ptr0_q;
  bmd_byte_t ptr1_d, ptr1_q;
  logic bank_d, bank_q;
  bmd_src_t src_d, src_q;
  bmd_byte_t hold_d, hold_q;
  logic [6:0] sfr_addr_d, sfr_addr_q;
  logic sfr_rd_d, sfr_rd_q;
  logic sfr_wr_d, sfr_wr_q;
  bmd_byte_t sfr_wdata_d, sfr_wdata_q;
  bmd_byte_t sfr_wmask_d, sfr_wmask_q;

  // Address resolution and target decoding for the access offered this cycle.
  always_comb
  begin
    is_wr = acc_wr_i | acc_bset_i | acc_bclr_i;
    is_acc = is_wr | acc_rd_i;
    wmask = make_mask(acc_wr_i, acc_bset_i | acc_bclr_i, acc_bit_i);
    wdata = make_data(acc_wr_i, acc_bset_i, acc_wdata_i);
    ind0 = (acc_addr_i == ADDR_IND0);
    ind1 = (acc_addr_i == ADDR_IND1);
    eff_addr = ind0 ? ptr0_q : (ind1 ? ptr1_q : acc_addr_i);
    eff_bank1 = ind1 & bank_q;
    if (!is_acc)
    begin
      tgt_d = TGT_NONE;
    end
    else if ((ind0 | ind1) && (eff_addr == ADDR_IND0 || eff_addr == ADDR_IND1))
    begin
      tgt_d = TGT_NONE;
    end
    else if (eff_addr >= ADDR_GP_BASE)
    begin
      tgt_d = (!eff_bank1 && in_gp(eff_addr)) ? TGT_MEM : TGT_NONE;
    end
    else if (eff_addr == ADDR_EEC)
    begin
      tgt_d = eff_bank1 ? TGT_SFR : TGT_NONE;
    end
    else if (eff_addr == ADDR_PTR0)
    begin
      tgt_d = TGT_PTR0;
    end
    else if (eff_addr == ADDR_PTR1)
    begin
      tgt_d = TGT_PTR1;
    end
    else if (eff_addr == ADDR_BANK)
    begin
      tgt_d = TGT_BANK;
    end
    else
    begin
      tgt_d = SFR_UNUSED_MAP[eff_addr[6:0]] ? TGT_NONE : TGT_SFR;
    end
  end

  // Pointer and bank registers.
  always_comb
  begin
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    bank_d = bank_q;
    if (is_wr)
    begin
      if (tgt_d == TGT_PTR0)
      begin
        ptr0_d = apply_mask(ptr0_q, wdata, wmask);
      end
      if (tgt_d == TGT_PTR1)
      begin
        ptr1_d = apply_mask(ptr1_q, wdata, wmask);
      end
      if (tgt_d == TGT_BANK)
      begin
        bank_d = wmask[BANK_BIT] ? wdata[BANK_BIT] : bank_q;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      ptr0_q <= PTR_RST;
      ptr1_q <= PTR_RST;
      if (!wdt_pd_reset_i)
      begin
        bank_q <= BANK_RST;
      end
    end
    else
    begin
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
      bank_q <= bank_d;
    end
  end

  // Read source selection and peripheral register strobes.
  always_comb
  begin
    src_d = SRC_ZERO;
    hold_d = ZERO_BYTE;
    if (acc_rd_i)
    begin
      unique case (tgt_d)
        TGT_NONE: src_d = SRC_ZERO;
        TGT_PTR0:
        begin
          src_d = SRC_HOLD;
          hold_d = ptr0_q;
        end
        TGT_PTR1:
        begin
          src_d = SRC_HOLD;
          hold_d = ptr1_q;
        end
        TGT_BANK:
        begin
          src_d = SRC_HOLD;
          hold_d = ZERO_BYTE;
          hold_d[BANK_BIT] = bank_q;
        end
        TGT_SFR: src_d = SRC_SFR;
        TGT_MEM: src_d = SRC_MEM;
      endcase
    end
    sfr_addr_d = eff_addr[6:0];
    sfr_rd_d = acc_rd_i && (tgt_d == TGT_SFR);
    sfr_wr_d = is_wr && (tgt_d == TGT_SFR) && !SFR_PROT_MAP[eff_addr[6:0]];
    sfr_wdata_d = wdata;
    sfr_wmask_d = wmask;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      src_q <= SRC_ZERO;
      hold_q <= ZERO_BYTE;
      sfr_addr_q <= ZERO_BYTE[6:0];
      sfr_rd_q <= 1'b0;
      sfr_wr_q <= 1'b0;
      sfr_wdata_q <= ZERO_BYTE;
      sfr_wmask_q <= ZERO_BYTE;
    end
    else
    begin
      src_q <= src_d;
      hold_q <= hold_d;
      sfr_addr_q <= sfr_addr_d;
      sfr_rd_q <= sfr_rd_d;
      sfr_wr_q <= sfr_wr_d;
      sfr_wdata_q <= sfr_wdata_d;
      sfr_wmask_q <= sfr_wmask_d;
    end
  end

  // The general area maps 80H upward onto the store's index.
  assign mem_bus.addr = eff_addr[GP_AW-1:0];
  assign mem_bus.rd_en = acc_rd_i && (tgt_d == TGT_MEM);
  assign mem_bus.wr_en = is_wr && (tgt_d == TGT_MEM);
  assign mem_bus.wdata = wdata;
  assign mem_bus.wmask = wmask;

  bmd_mem u_mem (
    .core_clk_i (core_clk_i),
    .reset_n_i (reset_n_i),
    .mem (mem_bus.store)
  );

  always_comb
  begin
    unique case (src_q)
      SRC_ZERO: acc_rdata_o = ZERO_BYTE;
      SRC_HOLD: acc_rdata_o = hold_q;
      SRC_SFR: acc_rdata_o = sfr_rdata_i;
      SRC_MEM: acc_rdata_o = mem_bus.rdata;
    endcase
  end

  assign sfr_addr_o = sfr_addr_q;
  assign sfr_rd_o = sfr_rd_q;
  assign sfr_wr_o = sfr_wr_q;
  assign sfr_wdata_o = sfr_wdata_q;
  assign sfr_wmask_o = sfr_wmask_q;
  assign bank_sel_o = bank_q;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  bank_clear_a: assert property (disable iff (1'b0)
    (!reset_n_i && !wdt_pd_reset_i) |=> !bank_sel_o)
    else $error("bank select not cleared by reset");
  bank_keep_a: assert property (disable iff (1'b0)
    (!reset_n_i && wdt_pd_reset_i) |=> $stable(bank_sel_o))
    else $error("bank select changed by power down watchdog reset");
  unused_zero_a: assert property (
    (acc_rd_i && tgt_d == TGT_NONE) |=> (acc_rdata_o == ZERO_BYTE))
    else $error("unused location did not read zero");
  prot_write_a: assert property (
    (is_wr && tgt_d == TGT_SFR && SFR_PROT_MAP[eff_addr[6:0]]) |=> !sfr_wr_o)
    else $error("write reached a protected register");
  direct_bank_a: assert property (
    (acc_rd_i && !ind0 && !ind1 && bank_q && in_gp(acc_addr_i)) |-> (tgt_d == TGT_MEM))
    else $error("direct access left bank 0");
  port_zero_a: assert property (
    (acc_rd_i && ind0 && bank_q && in_gp(ptr0_q)) |-> mem_bus.rd_en)
    else $error("port zero missed bank 0 RAM");
  eec_bank1_a: assert property (
    (acc_rd_i && ind1 && bank_q && ptr1_q == ADDR_EEC)
      |=> (sfr_rd_o && sfr_addr_o == ADDR_EEC[6:0]))
    else $error("EEPROM control register not reached in bank 1");
  bank1_gp_a: assert property (
    (acc_rd_i && ind1 && bank_q && ptr1_q >= ADDR_GP_BASE) |=> (acc_rdata_o == ZERO_BYTE))
    else $error("bank 1 general area did not read zero");
  bank_bits_a: assert property (
    (acc_rd_i && !acc_wr_i && acc_addr_i == ADDR_BANK) |=> (acc_rdata_o[7:1] == 7'h00))
    else $error("upper bank select bits not zero");
  mem_round_a: assert property (
    (acc_wr_i && !acc_rd_i && tgt_d == TGT_MEM && !ind0 && !ind1)
      ##1 (acc_rd_i && !is_wr && acc_addr_i == $past(acc_addr_i))
      |=> (acc_rdata_o == $past(acc_wdata_i, 2)))
    else $error("general byte did not return written data");

  ind1_bank1_c: cover property (acc_rd_i && ind1 && bank_q && tgt_d == TGT_SFR);
  bit_set_c: cover property (acc_bset_i && tgt_d == TGT_MEM);
  prot_write_c: cover property (is_wr && tgt_d == TGT_SFR && SFR_PROT_MAP[eff_addr[6:0]]);
  wdt_keep_c: cover property (disable iff (1'b0) !reset_n_i && wdt_pd_reset_i && bank_q);

endmodule

// ### bmd_sfr_model.sv
// Peripheral register file that answers the decoder's special function port.
`timescale 1ns/1ps
module bmd_sfr_model
  import bmd_pkg::*;
(
  // Clock.
  input wire logic core_clk_i,
  // Register port.
  input wire logic [6:0] sfr_addr_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_wr_i,
  input wire bmd_pkg::bmd_byte_t sfr_wdata_i,
  input wire bmd_pkg::bmd_byte_t sfr_wmask_i,
  output bmd_pkg::bmd_byte_t sfr_rdata_o
);
  bmd_byte_t regs [0:127];
  logic tick = 1'b0;

  initial
  begin
    for (int i = 0; i < 128; i++)
    begin
      regs[i] = 8'(i) ^ 8'h5A;
    end
  end

  // Only the bits named by the mask are written.
  always @(posedge core_clk_i)
  begin
    tick <= ~tick;
    if (sfr_wr_i)
    begin
      regs[sfr_addr_i] <= (regs[sfr_addr_i] & ~sfr_wmask_i) | (sfr_wdata_i & sfr_wmask_i);
    end
  end

  // An unselected bus shows a pattern that changes every cycle.
  assign sfr_rdata_o = sfr_rd_i ? regs[sfr_addr_i] : {8{tick}};
endmodule

// ### test_bmd_top.sv
// Self-checking bench for the banked data memory decoder.
`timescale 1ns/1ps
module test_bmd_top;
  import bmd_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wdt = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic bset = 1'b0;
  logic bclr = 1'b0;
  logic [2:0] bitn = 3'h0;
  bmd_byte_t wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] rdata_small;
  logic [6:0] sfr_addr;
  logic sfr_rd;
  logic sfr_wr;
  bmd_byte_t sfr_wdata;
  bmd_byte_t sfr_wmask;
  bmd_byte_t sfr_rdata;
  logic bank_sel;
  int miscompares = 0;
  int num_checks = 0;

  always #50 core_clk_i = ~core_clk_i;

  bmd_top #(.LARGE_VARIANT(1'b1)) uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .wdt_pd_reset_i(wdt), .acc_addr_i(addr), .acc_rd_i(rd), .acc_wr_i(wr),
    .acc_bset_i(bset), .acc_bclr_i(bclr), .acc_bit_i(bitn), .acc_wdata_i(wdata),
    .acc_rdata_o(rdata), .sfr_addr_o(sfr_addr), .sfr_rd_o(sfr_rd), .sfr_wr_o(sfr_wr),
    .sfr_wdata_o(sfr_wdata), .sfr_wmask_o(sfr_wmask), .sfr_rdata_i(sfr_rdata),
    .bank_sel_o(bank_sel));

  bmd_top #(.LARGE_VARIANT(1'b0)) uut_small (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .wdt_pd_reset_i(wdt), .acc_addr_i(addr), .acc_rd_i(rd), .acc_wr_i(wr),
    .acc_bset_i(bset), .acc_bclr_i(bclr), .acc_bit_i(bitn), .acc_wdata_i(wdata),
    .acc_rdata_o(rdata_small), .sfr_addr_o(), .sfr_rd_o(), .sfr_wr_o(),
    .sfr_wdata_o(), .sfr_wmask_o(), .sfr_rdata_i(sfr_rdata), .bank_sel_o());

  bmd_sfr_model part (.core_clk_i(core_clk_i), .sfr_addr_i(sfr_addr), .sfr_rd_i(sfr_rd),
    .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata), .sfr_wmask_i(sfr_wmask),
    .sfr_rdata_o(sfr_rdata));

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access per cycle: 0 read, 1 write, 2 bit set, 3 bit clear.
  // The strobes stay up until the next access or a reset replaces them.
  task automatic op(input logic [7:0] a, input int k, input logic [2:0] b, input bmd_byte_t d);
    addr = a;
    rd = (k == 0);
    wr = (k == 1);
    bset = (k == 2);
    bclr = (k == 3);
    bitn = b;
    wdata = d;
    @(negedge core_clk_i);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    op(a, 0, 3'h0, 8'h00);
    chk(rdata, exp);
  endtask

  task automatic rst(input logic w);
    {rd, wr, bset, bclr} = 4'h0;
    reset_n_i = 1'b0;
    wdt = w;
    repeat (2) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    wdt = 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic t_reset;
    rdc(8'h01, 8'h00);
    rdc(8'h04, 8'h00);
    chk({7'h00, bank_sel}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_gp;
    op(8'h80, 1, 3'h0, 8'hA1);
    op(8'hFF, 1, 3'h0, 8'hB2);
    rdc(8'h80, 8'hA1);
    rdc(8'hFF, 8'hB2);
    op(8'hE0, 1, 3'h0, 8'h11);
    rdc(8'hE0, 8'h11);
    chk(rdata_small, 8'h00);
    op(8'hDF, 1, 3'h0, 8'h22);
    rdc(8'hDF, 8'h22);
    chk(rdata_small, 8'h22);
    op(8'h85, 1, 3'h0, 8'h5A);
    op(8'h85, 2, 3'h0, 8'h00);
    rdc(8'h85, 8'h5B);
    op(8'h85, 3, 3'h6, 8'h00);
    rdc(8'h85, 8'h1B);
    $display("test general bytes done");
  endtask

  task automatic t_unused;
    op(8'h0C, 1, 3'h0, 8'hAA);
    rdc(8'h0C, 8'h00);
    op(8'h40, 1, 3'h0, 8'hCC);
    rdc(8'h40, 8'h00);
    op(8'h08, 1, 3'h0, 8'hFF);
    op(8'h08, 2, 3'h0, 8'h00);
    rdc(8'h08, 8'h52);
    rdc(8'h7F, 8'h00);
    op(8'h20, 1, 3'h0, 8'h3C);
    op(8'h20, 3, 3'h2, 8'h00);
    rdc(8'h20, 8'h38);
    $display("test unused and special done");
  endtask

  task automatic t_bank;
    op(8'h04, 1, 3'h0, 8'hFF);
    rdc(8'h04, 8'h01);
    chk({7'h00, bank_sel}, 8'h01);
    rdc(8'h20, 8'h38);
    rdc(8'h85, 8'h1B);
    op(8'h03, 1, 3'h0, 8'h40);
    op(8'h02, 1, 3'h0, 8'h77);
    rdc(8'h02, 8'h77);
    op(8'h01, 1, 3'h0, 8'h40);
    rdc(8'h00, 8'h00);
    op(8'h03, 1, 3'h0, 8'h85);
    op(8'h02, 1, 3'h0, 8'h99);
    rdc(8'h02, 8'h00);
    op(8'h01, 1, 3'h0, 8'h85);
    rdc(8'h00, 8'h1B);
    op(8'h04, 1, 3'h0, 8'h00);
    rdc(8'h02, 8'h1B);
    op(8'h01, 1, 3'h0, 8'h00);
    rdc(8'h00, 8'h00);
    $display("test banks done");
  endtask

  task automatic t_wdt;
    op(8'h04, 1, 3'h0, 8'h01);
    rst(1'b1);
    rdc(8'h04, 8'h01);
    rst(1'b0);
    chk({7'h00, bank_sel}, 8'h00);
    $display("test reset kinds done");
  endtask

  initial
  begin
    repeat (12) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    @(negedge core_clk_i);
    t_reset();
    t_gp();
    t_unused();
    t_bank();
    t_wdt();
    end_sim();
  end

  initial
  begin
    #500_000;
    miscompares++;
    end_sim();
  end
endmodule
